// ### hdl/burst_seq_pkg.sv
// Shared types and constants for the external bus burst sequencer.
// Assumes one bus clock; the far side is a memory or peripheral slave.
package burst_seq_pkg;

  // Transfer size line codes
  localparam logic [1:0] SIZE_CODE_LONG = 2'h0;
  localparam logic [1:0] SIZE_CODE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_CODE_WORD = 2'h2;
  localparam logic [1:0] SIZE_CODE_LINE = 2'h3;

  localparam int          OPERAND_BITS  = 128;
  localparam int          MAX_BEATS     = 16;
  localparam logic [27:0] ADDR_RESET    = 28'h0000000;

  typedef enum logic [1:0] {OP_BYTE, OP_WORD, OP_LONG, OP_LINE} op_size_e;
  // Encoding equals log2 of the port width in bytes
  typedef enum logic [1:0] {PORT_8, PORT_16, PORT_32} port_size_e;
  typedef enum logic [1:0] {PH_IDLE, PH_START, PH_DATA} phase_e;

  typedef struct packed {
    logic [27:0]              addr;
    logic                     write;
    op_size_e                 op_size;
    port_size_e               port;
    logic                     burst_enable;
    logic                     dram;
    logic                     supervisor;
    logic                     code;
    logic [1:0]               ttype;
    logic [OPERAND_BITS-1:0]  wdata;
  } request_s;

  typedef struct packed {
    logic [OPERAND_BITS-1:0]  rdata;
    logic                     bus_error;
  } response_s;

  function automatic logic [4:0] op_bytes(op_size_e op);
    case (op)
      OP_BYTE: op_bytes = 5'h01;
      OP_WORD: op_bytes = 5'h02;
      OP_LONG: op_bytes = 5'h04;
      default: op_bytes = 5'h10;
    endcase
  endfunction : op_bytes

  function automatic logic [1:0] op_code(op_size_e op);
    case (op)
      OP_BYTE: op_code = SIZE_CODE_BYTE;
      OP_WORD: op_code = SIZE_CODE_WORD;
      OP_LONG: op_code = SIZE_CODE_LONG;
      default: op_code = SIZE_CODE_LINE;
    endcase
  endfunction : op_code

  function automatic logic [1:0] port_code(port_size_e p);
    case (p)
      PORT_8:  port_code = SIZE_CODE_BYTE;
      PORT_16: port_code = SIZE_CODE_WORD;
      default: port_code = SIZE_CODE_LONG;
    endcase
  endfunction : port_code

endpackage : burst_seq_pkg

// ### hdl/external_bus_burst_sequencer.sv
// Bus master sequencer: address, strobe, size and data phases of the external bus.
// Assumes ack and read data arrive from pins; results leave through a two-entry buffer.
//
// Function
// R01 - Write first clock: address, type, direction low, size code, start strobe low.
// R02 - Write second clock: strobe released, access line shows privilege, data driven.
// R03 - Slave acknowledges when ready; 16-bit slave takes upper data half.
// R04 - Write waits: data held, acknowledge resampled each edge until asserted.
// R05 - Burst when operand wider than port and burst enabled or target DRAM.
// R06 - Burst size lines carry operand code on every beat.
// R07 - DRAM with operand wider than port always bursts.
// R08 - Software clears burst enable for regions that cannot burst.
// R09 - Line read: four longwords, low four address bits stepped each beat.
// R10 - Longword read steps two low address bits on narrow ports.
// R11 - Word read steps lowest address bit on 8-bit port.
// R12 - Line write: four longwords, low four address bits stepped each beat.
// R13 - Longword write steps two low address bits on narrow ports.
// R14 - Word write steps lowest address bit on 8-bit port.
// R15 - Bursting read has two to sixteen beats.
// R16 - Bursting write has two to sixteen beats.
// R17 - Read first clock: address, type, direction high, operand size, strobe low.
// R18 - Access line shows code/data in first clock, privilege afterwards.
// R19 - 8-bit slave drives top byte lane; device latches it on acknowledge.
// R20 - Word burst to 8-bit port ends after second byte acknowledged.
// R21 - Read waits while acknowledge negated; data latched only when asserted.
// R22 - Without burst, size lines show the port size for wide operands.
// R23 - Enabled bus monitor ends an unacknowledged cycle with a bus error.
// R24 - Byte code marks a single-byte transfer.
// R25 - Start strobe asserted only in the first clock of a burst.
`timescale 1ns/1ps

module external_bus_burst_sequencer #(
  parameter int MONITOR_CYCLES = 1024
) (
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       req_valid_in,
  input  wire burst_seq_pkg::request_s    req_in,
  output logic                            req_ready_out,
  output logic                            rsp_valid_out,
  input  wire logic                       rsp_ready_in,
  output burst_seq_pkg::response_s        rsp_out,
  input  wire logic                       bus_monitor_enable_in,
  output logic [27:0]                     address_out,
  output logic [1:0]                      transfer_type_out,
  output logic                            access_kind_line_out,
  output logic                            read_not_write_out,
  output logic [1:0]                      transfer_size_out,
  output logic                            transfer_start_n_out,
  output logic [31:0]                     data_out,
  output logic                            data_oe_out,
  input  wire logic [31:0]                data_in,
  input  wire logic                       transfer_ack_n_in
);

  if (MONITOR_CYCLES < 2 || MONITOR_CYCLES > 65535) begin : g_bad
    $error("MONITOR_CYCLES out of range");
  end

  localparam logic [15:0] MON_LAST = 16'(MONITOR_CYCLES - 1);

  typedef struct packed {
    burst_seq_pkg::phase_e      phase;
    logic                       ack_s1;
    logic                       ack_s2;
    logic [31:0]                din_s1;
    logic [31:0]                din_s2;
    logic [27:0]                addr;
    logic [1:0]                 ttype;
    logic                       kind;
    logic                       rnw;
    logic [1:0]                 size;
    logic                       start_n;
    logic [31:0]                dout;
    logic                       doe;
    burst_seq_pkg::port_size_e  port;
    logic [4:0]                 opb;
    logic                       burst;
    logic                       sup;
    logic                       code;
    logic [4:0]                 beats_left;
    logic [127:0]               shreg;
    logic [127:0]               acc;
    logic [15:0]                mon;
    burst_seq_pkg::response_s   buf0;
    burst_seq_pkg::response_s   buf1;
    logic [1:0]                 count;
    logic                       ready;
    logic                       rvalid;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Write lanes mirrored so narrow operands reach every lane a slave may use
  function automatic logic [31:0] lanes(logic [127:0] sh, logic [4:0] opb);
    case (opb)
      5'h01:   lanes = {4{sh[127:120]}};
      5'h02:   lanes = {2{sh[127:112]}};
      default: lanes = sh[127:96];
    endcase
  endfunction : lanes

  always_comb begin
    logic                      wide;
    logic [3:0]                mask;
    logic [3:0]                low;
    logic [31:0]               lane_sh;
    logic [127:0]              acc_n;
    logic                      fin;
    burst_seq_pkg::response_s  rsp;
    wide    = 1'b0;
    mask    = 4'h0;
    low     = 4'h0;
    lane_sh = 32'h00000000;
    acc_n   = s_r.acc;
    fin     = 1'b0;
    rsp     = '0;
    s_nxt   = s_r;
    s_nxt.ack_s1 = transfer_ack_n_in;
    s_nxt.ack_s2 = s_r.ack_s1;
    s_nxt.din_s1 = data_in;
    s_nxt.din_s2 = s_r.din_s1;
    if (s_r.count != 2'h0 && rsp_ready_in) begin
      s_nxt.buf0  = s_r.buf1;
      s_nxt.count = s_r.count - 2'h1;
    end
    case (s_r.phase)
      burst_seq_pkg::PH_IDLE: begin
        if (req_valid_in && s_r.ready) begin
          wide         = burst_seq_pkg::op_bytes(req_in.op_size) > (5'h01 << req_in.port);
          s_nxt.burst  = wide && (req_in.burst_enable || req_in.dram);  // see R05 see R07
          s_nxt.port   = req_in.port;
          s_nxt.opb    = burst_seq_pkg::op_bytes(req_in.op_size);
          s_nxt.beats_left = wide ? (burst_seq_pkg::op_bytes(req_in.op_size) >> req_in.port)
                                  : 5'h01;  // see R15 see R16 see R20
          s_nxt.sup    = req_in.supervisor;
          s_nxt.code   = req_in.code;
          s_nxt.addr   = req_in.addr;
          s_nxt.ttype  = req_in.ttype;
          s_nxt.rnw    = !req_in.write;  // see R01 see R17
          s_nxt.kind   = req_in.code;    // see R18
          // Inhibited wide transfers report port size, otherwise operand size
          s_nxt.size   = (wide && !s_nxt.burst) ? burst_seq_pkg::port_code(req_in.port)
                         : burst_seq_pkg::op_code(req_in.op_size);  // see R06 see R22 see R24
          s_nxt.start_n = 1'b0;  // see R01 see R17
          s_nxt.shreg  = req_in.wdata << {5'h10 - burst_seq_pkg::op_bytes(req_in.op_size),
                                          3'h0};
          s_nxt.acc    = '0;
          s_nxt.phase  = burst_seq_pkg::PH_START;
        end
      end
      burst_seq_pkg::PH_START: begin
        s_nxt.start_n = 1'b1;  // see R02 see R25
        s_nxt.kind    = s_r.sup;  // see R18
        s_nxt.doe     = !s_r.rnw;
        s_nxt.dout    = lanes(s_r.shreg, s_r.opb);  // see R02 see R03
        s_nxt.mon     = 16'h0000;
        s_nxt.phase   = burst_seq_pkg::PH_DATA;
      end
      burst_seq_pkg::PH_DATA: begin
        if (!s_r.ack_s2) begin  // see R04 see R21
          lane_sh = s_r.din_s2 << {s_r.addr[1:0] & ((2'h1 << s_r.port) - 2'h1), 3'h0};
          case (s_r.port)  // see R19
            burst_seq_pkg::PORT_8:  acc_n = {s_r.acc[119:0], lane_sh[31:24]};
            burst_seq_pkg::PORT_16: acc_n = {s_r.acc[111:0], lane_sh[31:16]};
            default:                acc_n = {s_r.acc[95:0], lane_sh};
          endcase
          s_nxt.acc = acc_n;
          if (s_r.beats_left == 5'h01) begin
            fin = 1'b1;  // see R20
          end else begin
            // Step within the operand's aligned block, wrapping at its boundary
            mask = s_r.opb[3:0] - 4'h1 | {4{s_r.opb[4]}};
            low  = s_r.addr[3:0] + (4'h1 << s_r.port);
            s_nxt.addr[3:0] = (low & mask) | (s_r.addr[3:0] & ~mask);  // see R09 see R10
            s_nxt.beats_left = s_r.beats_left - 5'h01;  // see R11 see R12 see R13 see R14
            s_nxt.shreg = s_r.shreg << {(5'h01 << s_r.port), 3'h0};
            s_nxt.mon   = 16'h0000;
            if (s_r.burst) begin
              s_nxt.dout = lanes(s_nxt.shreg, s_r.opb);  // see R25
            end else begin
              s_nxt.start_n = 1'b0;
              s_nxt.kind    = s_r.code;
              s_nxt.phase   = burst_seq_pkg::PH_START;
            end
          end
        end else if (bus_monitor_enable_in && s_r.mon == MON_LAST) begin
          fin           = 1'b1;  // see R23
          rsp.bus_error = 1'b1;
        end else begin
          s_nxt.mon = s_r.mon + 16'h0001;
        end
      end
      default: s_nxt.phase = burst_seq_pkg::PH_IDLE;
    endcase
    if (fin) begin
      rsp.rdata   = s_r.rnw ? acc_n : '0;
      s_nxt.doe   = 1'b0;
      s_nxt.phase = burst_seq_pkg::PH_IDLE;
      if (s_nxt.count == 2'h0) begin
        s_nxt.buf0 = rsp;
      end else begin
        s_nxt.buf1 = rsp;
      end
      s_nxt.count = s_nxt.count + 2'h1;
    end
    // One transfer in flight and a free slot reserved, so a stalled reader drops nothing
    s_nxt.ready = (s_nxt.phase == burst_seq_pkg::PH_IDLE) && (s_nxt.count != 2'h2);
    // Registered copy so the valid output comes straight from a flop
    s_nxt.rvalid = (s_nxt.count != 2'h0);
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r         <= '0;
      s_r.phase   <= burst_seq_pkg::PH_IDLE;
      s_r.ack_s1  <= 1'b1;
      s_r.ack_s2  <= 1'b1;
      s_r.start_n <= 1'b1;
      s_r.rnw     <= 1'b1;
      s_r.addr    <= burst_seq_pkg::ADDR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_out        = s_r.ready;
  assign rsp_valid_out        = s_r.rvalid;
  assign rsp_out              = s_r.buf0;
  assign address_out          = s_r.addr;
  assign transfer_type_out    = s_r.ttype;
  assign access_kind_line_out = s_r.kind;
  assign read_not_write_out   = s_r.rnw;
  assign transfer_size_out    = s_r.size;
  assign transfer_start_n_out = s_r.start_n;
  assign data_out             = s_r.dout;
  assign data_oe_out          = s_r.doe;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_start_one_clock: assert property ( // see R02
    !transfer_start_n_out |=> transfer_start_n_out && access_kind_line_out == s_r.sup)
    else $error("start strobe held or privilege not shown in second clock");
  a_write_data_out: assert property ( // see R01
    !transfer_start_n_out && !read_not_write_out |=> data_oe_out ##0 !read_not_write_out)
    else $error("write data not driven after first clock");
  a_wait_holds_bus: assert property ( // see R04
    s_r.phase == burst_seq_pkg::PH_DATA && s_r.ack_s2 && s_r.mon != MON_LAST
    |=> $stable(data_out) && $stable(address_out) && s_r.phase == burst_seq_pkg::PH_DATA)
    else $error("bus changed during wait state");
  a_burst_size_code: assert property ( // see R06
    s_r.burst && s_r.phase != burst_seq_pkg::PH_IDLE
    |-> transfer_size_out == (s_r.opb == 5'h10 ? burst_seq_pkg::SIZE_CODE_LINE :
        s_r.opb == 5'h04 ? burst_seq_pkg::SIZE_CODE_LONG : burst_seq_pkg::SIZE_CODE_WORD))
    else $error("burst size code is not the operand code");
  a_inhibit_port_size: assert property ( // see R22
    !s_r.burst && s_r.beats_left > 5'h01 && s_r.phase != burst_seq_pkg::PH_IDLE
    |-> transfer_size_out == burst_seq_pkg::port_code(s_r.port))
    else $error("inhibited size code is not the port code");
  a_no_restrobe_burst: assert property ( // see R25
    s_r.burst && s_r.phase == burst_seq_pkg::PH_DATA |-> transfer_start_n_out)
    else $error("start strobe repeated inside a burst");
  a_block_addr_fixed: assert property ( // see R09
    s_r.phase == burst_seq_pkg::PH_DATA ##1 s_r.phase != burst_seq_pkg::PH_IDLE
    |-> address_out[27:4] == $past(address_out[27:4]))
    else $error("address left the aligned block");
  a_beat_count_range: assert property ( // see R15
    $rose(s_r.phase == burst_seq_pkg::PH_START) && s_r.burst
    |-> s_r.beats_left >= 5'h02 && s_r.beats_left <= 5'h10)
    else $error("burst beat count out of range");
  a_monitor_ends: assert property ( // see R23
    s_r.phase == burst_seq_pkg::PH_DATA && s_r.ack_s2 && bus_monitor_enable_in &&
    s_r.mon == MON_LAST |=> s_r.phase == burst_seq_pkg::PH_IDLE && rsp_valid_out && !data_oe_out)
    else $error("bus monitor did not end the cycle");
  // Request fields are checked against the values taken one clock earlier
  a_first_clock_ctrl: assert property ( // see R17
    req_valid_in && req_ready_out |=> !transfer_start_n_out &&
    read_not_write_out == !$past(req_in.write) && address_out == $past(req_in.addr) &&
    transfer_type_out == $past(req_in.ttype) && access_kind_line_out == $past(req_in.code))
    else $error("first clock control lines do not match the request");
  a_wait_no_latch: assert property ( // see R21
    s_r.phase == burst_seq_pkg::PH_DATA && s_r.ack_s2 |=> $stable(s_r.acc))
    else $error("read data latched without acknowledge");
  a_byte_size_code: assert property ( // see R24
    $fell(transfer_start_n_out) && s_r.opb == 5'h01
    |-> transfer_size_out == burst_seq_pkg::SIZE_CODE_BYTE)
    else $error("single byte transfer without byte size code");
  a_word_two_beats: assert property ( // see R20
    $rose(s_r.phase == burst_seq_pkg::PH_START) && s_r.burst && s_r.opb == 5'h02
    |-> s_r.beats_left == 5'h02)
    else $error("word burst is not two beats");
  a_dram_always_burst: assert property ( // see R07
    req_valid_in && req_ready_out && req_in.dram &&
    burst_seq_pkg::op_bytes(req_in.op_size) > (5'h01 << req_in.port) |=> s_r.burst)
    else $error("wide dram transfer not run as a burst");

  c_line_write_burst: cover property (
    s_r.burst && !read_not_write_out && s_r.opb == 5'h10 && s_r.beats_left == 5'h01 && !s_r.ack_s2);
  c_read_wait_state: cover property (
    read_not_write_out && s_r.phase == burst_seq_pkg::PH_DATA && s_r.ack_s2 ##1 !s_r.ack_s2);
  c_monitor_error: cover property (rsp_valid_out && rsp_out.bus_error);
  c_inhibited_restart: cover property (
    !s_r.burst && s_r.beats_left > 5'h01 ##1 !transfer_start_n_out);
  c_word_burst_8bit: cover property (
    $rose(s_r.phase == burst_seq_pkg::PH_START) && s_r.burst && s_r.opb == 5'h02);

endmodule : external_bus_burst_sequencer

// ### verif/bus_slave_model.sv
// Memory-side model of the external bus: one ack pulse per beat after a set wait.
// Assumes the sequencer's pins; beats_in gives the beat count of the coming transfer.
`timescale 1ns/1ps
module bus_slave_model (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [27:0] address_in,
  input  wire logic        start_n_in,
  input  wire logic [31:0] data_out_in,
  input  wire logic [7:0]  wait_in,
  input  wire logic [4:0]  beats_in,
  output logic             ack_n_out,
  output logic [31:0]      data_in_out
);
  logic [27:0] alog [0:15];
  logic [31:0] wlog [0:15];
  logic [27:0] prev_a;
  logic [7:0]  wcnt;
  logic [4:0]  left, n;
  logic        armed, fire, st;
  int          wn;
  wire  [31:0] pat = {address_in[7:0] ^ 8'h3c, 8'(address_in + 1) ^ 8'h3c,
                      8'(address_in + 2) ^ 8'h3c, 8'(address_in + 3) ^ 8'h3c};

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_n_out <= 1'b1;
      armed <= 1'b0;
      left <= 5'h00;
      wn <= 0;
    end else begin
      // New beat: a start strobe, or a fresh address inside a burst
      st = !start_n_in || (left != 5'h00 && address_in != prev_a);
      n = (!start_n_in && left == 5'h00) ? beats_in : left;
      fire = armed ? (wcnt == 8'h00) : (st && wait_in == 8'h00);
      prev_a <= address_in;
      ack_n_out <= !fire;
      // Lanes outside an ack show the inverse, never a stale match
      data_in_out <= fire ? pat : ~pat;
      if (!start_n_in && left == 5'h00) wn <= 0;
      if (fire) begin
        armed <= 1'b0;
        left <= n - 5'h01;
      end else if (armed) begin
        wcnt <= wcnt - 8'h01;
      end else if (st) begin
        armed <= 1'b1;
        wcnt <= wait_in - 8'h01;
        left <= n;
      end
      // Write data taken at the end of the acknowledged clock
      if (!ack_n_out) begin
        alog[wn] <= address_in;
        wlog[wn] <= data_out_in;
        wn <= wn + 1;
      end
    end
  end
endmodule : bus_slave_model

// ### verif/testbench.sv
// Self-checking bench for the burst sequencer with a memory-side model.
// Assumes a 20 MHz bus clock and the monitor shortened to 8 cycles.
`timescale 1ns/1ps
module testbench;
  logic        clock_in, rst_n_in, req_valid_in, rsp_ready_in, mon_en;
  logic        req_ready_out, rsp_valid_out, kind_line, rnw, start_n, oe, ack_n;
  logic        rw_seen, kind1, kind2, st_q;
  logic [1:0]  ttype, size, size_seen, tt_seen;
  logic [27:0] address;
  logic [31:0] dout, din;
  logic [7:0]  wait_cyc;
  logic [4:0]  beats;
  int          bad_count, n_tests, n_strobe;
  burst_seq_pkg::request_s  req_in;
  burst_seq_pkg::response_s rsp_out;

  external_bus_burst_sequencer #(.MONITOR_CYCLES(8)) dut_u (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in),
    .rsp_out(rsp_out), .bus_monitor_enable_in(mon_en), .address_out(address),
    .transfer_type_out(ttype), .access_kind_line_out(kind_line), .read_not_write_out(rnw),
    .transfer_size_out(size), .transfer_start_n_out(start_n), .data_out(dout),
    .data_oe_out(oe), .data_in(din), .transfer_ack_n_in(ack_n));

  bus_slave_model partner_u (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .address_in(address), .start_n_in(start_n),
    .data_out_in(dout), .wait_in(wait_cyc), .beats_in(beats), .ack_n_out(ack_n),
    .data_in_out(din));

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // First-strobe snapshot of the control lines, and strobe count per transfer
  always @(posedge clock_in) begin
    if (st_q && n_strobe == 1) kind2 <= kind_line;
    st_q <= !start_n;
    if (!start_n) n_strobe <= n_strobe + 1;
    if (!start_n && n_strobe == 0) begin
      size_seen <= size;
      rw_seen <= rnw;
      kind1 <= kind_line;
      tt_seen <= ttype;
    end
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic give_up;
    check(1'b0, 1'b1);
    summarize();
  endtask : give_up

  task automatic issue(input burst_seq_pkg::request_s r);
    int i;
    @(posedge clock_in);
    req_in <= r;
    req_valid_in <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge clock_in);
      if (req_ready_out === 1'b1) break;
    end
    req_valid_in <= 1'b0;
    if (i == 300) give_up();
  endtask : issue

  task automatic collect(output burst_seq_pkg::response_s r);
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge clock_in);
      if (rsp_valid_out === 1'b1 && rsp_ready_in === 1'b1) break;
    end
    r = rsp_out;
    if (i == 600) give_up();
  endtask : collect

  function automatic logic [1:0] size_code(input int b);
    case (b)
      1: return burst_seq_pkg::SIZE_CODE_BYTE;
      2: return burst_seq_pkg::SIZE_CODE_WORD;
      4: return burst_seq_pkg::SIZE_CODE_LONG;
      default: return burst_seq_pkg::SIZE_CODE_LINE;
    endcase
  endfunction : size_code

  function automatic burst_seq_pkg::request_s mk(input int oi, input int pi, input logic wr,
      input logic be, input logic dr, input logic sup, input logic cd, input logic [27:0] a,
      input logic [127:0] wd);
    return '{addr: a, write: wr, op_size: burst_seq_pkg::op_size_e'(oi),
             port: burst_seq_pkg::port_size_e'(pi), burst_enable: be, dram: dr,
             supervisor: sup, code: cd, ttype: 2'h2, wdata: wd};
  endfunction : mk

  // Op 0..3 is byte..line, port 0..2 is 8..32 bits
  task automatic xfer(input int oi, input int pi, input logic wr, input logic be,
      input logic dr, input logic sup, input logic cd, input logic [27:0] a,
      input logic [127:0] wd, input logic [7:0] w);
    burst_seq_pkg::response_s s;
    int nb, pb, nbeat, k, j;
    logic bst;
    logic [27:0] ak;
    logic [127:0] ex;
    nb = (oi == 3) ? 16 : (1 << oi);
    pb = 1 << pi;
    bst = nb > pb && (be || dr);
    nbeat = nb > pb ? nb / pb : 1;
    wait_cyc <= w;
    beats <= 5'(nbeat);
    n_strobe <= 0;
    issue(mk(oi, pi, wr, be, dr, sup, cd, a, wd));
    collect(s);
    ex = '0;
    for (k = 0; k < nbeat; k++) begin
      // Beat address wraps inside the operand's aligned block
      ak = nb > pb ? 28'((a & ~(nb - 1)) | ((a + k * pb) & (nb - 1))) : a;
      check(partner_u.alog[k], ak);
      // Reads return the whole port width, narrow operands included
      for (j = 0; j < pb; j++) begin
        ex = {ex[119:0], 8'(ak + j) ^ 8'h3c};
        if (wr && j < nb)
          check(partner_u.wlog[k][31 - 8 * j -: 8], wd[8 * (nb - 1 - k * pb - j) +: 8]);
      end
    end
    check(partner_u.wn, nbeat);
    check(n_strobe, bst ? 1 : nbeat);
    check(size_seen, size_code(nb > pb && !bst ? pb : nb));
    check({tt_seen, rw_seen, kind1, kind2}, {2'h2, !wr, cd, sup});
    check(s.rdata, wr ? 128'h0 : ex);
    check({s.bus_error, oe}, 2'b00);
    $display("test done at %0t", $time);
  endtask : xfer

  task automatic t_buffer;
    burst_seq_pkg::response_s s;
    rsp_ready_in <= 1'b0;
    wait_cyc <= 8'h02;
    beats <= 5'h01;
    issue(mk(0, 2, 0, 0, 0, 1, 0, 28'h0000040, '0));
    issue(mk(0, 2, 0, 0, 0, 1, 0, 28'h0000044, '0));
    // Second result lands a few clocks after its ack; both now parked
    repeat (12) @(posedge clock_in);
    check(req_ready_out, 1'b0);
    rsp_ready_in <= 1'b1;
    collect(s);
    check(s.rdata, 128'h7c7d7e7f);
    collect(s);
    check(s.rdata, 128'h78797a7b);
    $display("test buffer done at %0t", $time);
  endtask : t_buffer

  task automatic t_timeout;
    burst_seq_pkg::response_s s;
    mon_en <= 1'b1;
    wait_cyc <= 8'h40;
    beats <= 5'h01;
    issue(mk(2, 2, 0, 0, 0, 1, 0, 28'h0000050, '0));
    collect(s);
    check(s.bus_error, 1'b1);
    $display("test timeout done at %0t", $time);
  endtask : t_timeout

  task automatic t_word_wr16;
    xfer(1, 1, 1, 0, 0, 1, 0, 28'h0001230, 128'hbeef, 8'h02);
  endtask : t_word_wr16

  task automatic t_word_rd8;
    xfer(1, 0, 0, 1, 0, 0, 1, 28'h0000456, '0, 8'h00);
  endtask : t_word_rd8

  task automatic t_line_rd_wrap;
    xfer(3, 2, 0, 1, 0, 1, 1, 28'h0000a34, '0, 8'h01);
  endtask : t_line_rd_wrap

  task automatic t_long_rd_inh;
    xfer(2, 1, 0, 0, 0, 1, 0, 28'h0000c08, '0, 8'h00);
  endtask : t_long_rd_inh

  task automatic t_line_wr_dram;
    xfer(3, 0, 1, 0, 1, 0, 0, 28'h0001100, 128'h00112233445566778899aabbccddeeff,
         8'h00);
  endtask : t_line_wr_dram

  task automatic t_long_wr_inh;
    xfer(2, 0, 1, 0, 0, 1, 0, 28'h0002004, 128'hcafe1234, 8'h01);
  endtask : t_long_wr_inh

  task automatic t_burst_mix;
    xfer(2, 1, 1, 1, 0, 1, 1, 28'h0002408, 128'h89abcdef, 8'h00);
    xfer(1, 0, 1, 1, 0, 0, 0, 28'h0002222, 128'h5aa5, 8'h00);
    xfer(3, 1, 0, 0, 1, 0, 1, 28'h0003010, '0, 8'h02);
    xfer(0, 2, 0, 0, 0, 1, 0, 28'h0003300, '0, 8'h00);
  endtask : t_burst_mix

  initial begin
    rst_n_in = 1'b0;
    req_valid_in = 1'b0;
    rsp_ready_in = 1'b1;
    mon_en = 1'b0;
    req_in = '0;
    wait_cyc = 8'h00;
    beats = 5'h01;
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_word_wr16();
    t_word_rd8();
    t_line_rd_wrap();
    t_long_rd_inh();
    t_line_wr_dram();
    t_long_wr_inh();
    t_burst_mix();
    t_buffer();
    t_timeout();
    summarize();
  end
endmodule : testbench
